// [pclk_pkg.sv]
// constants and field layout of the programmable clock and switch block
//------------------------------------------------------------------
//------------------------------------------------------------------
package pclk_pkg;
  localparam int NUM_PCK = 3;
  // register byte offsets
  localparam logic [7:0] ADR_PCER = 8'h00;
  localparam logic [7:0] ADR_PCDR = 8'h04;
  localparam logic [7:0] ADR_PCSR = 8'h08;
  localparam logic [7:0] ADR_SCER = 8'h0C;
  localparam logic [7:0] ADR_SCDR = 8'h10;
  localparam logic [7:0] ADR_SCSR = 8'h14;
  localparam logic [7:0] ADR_MCKR = 8'h18;
  localparam logic [7:0] ADR_LOCK = 8'h1C;
  localparam logic [7:0] ADR_SR = 8'h20;
  localparam logic [7:0] ADR_ISR = 8'h24;
  localparam logic [7:0] ADR_IMR = 8'h28;
  localparam logic [7:0] ADR_PCK0 = 8'h40;
  // fields
  localparam int CSS_LSB = 0;
  localparam int PROGCLK_PRESCALER_LSB = 4;
  localparam int MCK_CSS_LSB = 0;
  localparam int MCK_PROGCLK_PRESCALER_BIT = 4;
  localparam int MCKRDY_BIT = 8;
  localparam int STAT_W = 9;
  // source encodings
  localparam logic [2:0] SRC_SLOW = 3'h0;
  localparam logic [2:0] SRC_MAIN = 3'h1;
  localparam logic [2:0] SRC_MCK = 3'h2;
  localparam logic [2:0] SRC_PLLA = 3'h3;
  localparam logic [2:0] SRC_UPLL = 3'h4;
  localparam logic [1:0] MCK_SLOW = 2'h0;
  localparam logic [1:0] MCK_MAIN = 2'h1;
  localparam logic [1:0] MCK_PLLA = 2'h2;
  localparam logic [1:0] MCK_UPLL = 2'h3;
  // reset values and response codes
  localparam logic [2:0] CSS_RST = SRC_SLOW;
  localparam logic [7:0] PROGCLK_PRESCALER_RST = 8'h00;
  localparam logic [7:0] LOCK_RST = 8'h3F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing counts, in edges of the clock named
  localparam logic [1:0] READY_EDGES = 2'h2;
  localparam logic [8:0] MCK_PROGCLK_PRESCALER_EXTRA = 9'h040;
  localparam logic [3:0] SW_S2M_SLOW = 4'h4;
  localparam logic [3:0] SW_S2M_NEW = 4'h2;
  localparam logic [3:0] SW_M2S_SLOW = 4'h4;
  localparam logic [3:0] SW_S2P_SLOW = 4'h5;
  localparam logic [3:0] SW_S2P_NEW = 4'h2;
  localparam logic [3:0] SW_P2S_OLD = 4'h3;
  localparam logic [3:0] SW_P2S_SLOW = 4'h5;
  localparam logic [3:0] SW_X2P_SLOW = 4'h4;
  localparam logic [3:0] SW_X2P_NEW = 4'h2;
  localparam logic [3:0] SW_P2M_OLD = 4'h3;
  localparam logic [3:0] SW_P2M_NEW = 4'h1;
  localparam logic [3:0] SW_P2P_NEW = 4'h4;
endpackage

// [pclk_divider.sv]
// one programmable clock output: source mux, prescaler and ready flag
`timescale 1ns/10ps
module pclk_divider import pclk_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [2:0] srcSel,
  input wire logic [7:0] progclk_prescaler,
  input wire logic mainTick,
  input wire logic slowTick,
  input wire logic pllaTick,
  input wire logic upllTick,
  output logic pckOut,
  output logic ready
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [1:0] seen;
    logic out;
    logic rdy;
  } pclk_div_t;
  pclk_div_t s_ff, nxt_s;
  logic srcTick;

  //------------------------------------------------------------------
  // source mux and divider
  //------------------------------------------------------------------
  always_comb begin
    unique case (srcSel)
      SRC_MAIN: srcTick = mainTick;
      SRC_MCK: srcTick = 1'b1;
      SRC_PLLA: srcTick = pllaTick;
      SRC_UPLL: srcTick = upllTick;
      default: srcTick = slowTick;
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.out = 1'b0;
    if (!enable) begin
      nxt_s = '0;
    end else if (srcTick) begin
      if (s_ff.cnt == progclk_prescaler) begin
        nxt_s.cnt = 8'h00;
        nxt_s.out = 1'b1;
        if (s_ff.seen != READY_EDGES) begin
          nxt_s.seen = s_ff.seen + 2'h1;
        end
      end else begin
        nxt_s.cnt = s_ff.cnt + 8'h01;
      end
    end
    // two whole output periods before declaring the clock stable
    nxt_s.rdy = enable && (nxt_s.seen == READY_EDGES);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pckOut = s_ff.out;
  assign ready = s_ff.rdy;

  //------------------------------------------------------------------
  // checks
  //------------------------------------------------------------------
  sequence s_disabled;
    !enable;
  endsequence
  property p_rdyDrop;
    @(posedge clk) disable iff (rst) s_disabled |=> !ready && !pckOut;
  endproperty
  a_rdyDrop: assert property (p_rdyDrop) else $error("ready kept while off");
  property p_outTick;
    @(posedge clk) disable iff (rst) pckOut |-> $past(srcTick && enable);
  endproperty
  a_outTick: assert property (p_outTick) else $error("output without tick");
  property p_rdyAfterOut;
    @(posedge clk) disable iff (rst) $rose(ready) |-> pckOut && $past(enable);
  endproperty
  a_rdyAfterOut: assert property (p_rdyAfterOut) else $error("early ready");
endmodule

// [pclk_mck_switch.sv]
// master clock source switch with worst-case sequencing
`timescale 1ns/10ps
module pclk_mck_switch import pclk_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] tgtSel,
  input wire logic presOn,
  input wire logic [7:0] lockCnt,
  input wire logic mainTick,
  input wire logic slowTick,
  input wire logic pllaTick,
  input wire logic upllTick,
  output logic [1:0] curSel,
  output logic busy,
  output logic donePulse
);
  typedef enum logic [2:0] {
    PCLK_SW_IDLE, PCLK_SW_OLD, PCLK_SW_SLOW, PCLK_SW_NEW, PCLK_SW_PROGCLK_PRESCALER
  } pclk_sw_t;
  typedef struct packed {
    pclk_sw_t st;
    logic [1:0] cur;
    logic [1:0] tgt;
    logic [8:0] cnt;
    logic [3:0] oldN;
    logic [8:0] slowN;
    logic [3:0] newN;
    logic busy;
    logic done;
  } pclk_swst_t;
  pclk_swst_t s_ff, nxt_s;
  logic [8:0] lockExt;

  function automatic logic selTick(input logic [1:0] sel, input logic m,
                                   input logic sl, input logic a,
                                   input logic u);
    unique case (sel)
      MCK_MAIN: selTick = m;
      MCK_PLLA: selTick = a;
      MCK_UPLL: selTick = u;
      default: selTick = sl;
    endcase
  endfunction

  //------------------------------------------------------------------
  // phase plan: old-clock edges, slow edges, new-clock edges
  //------------------------------------------------------------------
  always_comb begin
    lockExt = {1'b0, lockCnt};
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    unique case (s_ff.st)
      PCLK_SW_IDLE: begin
        if (tgtSel != s_ff.cur) begin
          nxt_s.tgt = tgtSel;
          nxt_s.cnt = 9'h000;
          nxt_s.busy = 1'b1;
          nxt_s.st = PCLK_SW_OLD;
          nxt_s.oldN = 4'h0;
          nxt_s.newN = 4'h0;
          nxt_s.slowN = {5'h00, SW_M2S_SLOW};
          if (tgtSel == MCK_MAIN && s_ff.cur == MCK_SLOW) begin
            nxt_s.slowN = {5'h00, SW_S2M_SLOW};
            nxt_s.newN = SW_S2M_NEW;
          end else if (tgtSel[1] && s_ff.cur == MCK_SLOW) begin
            nxt_s.slowN = {5'h00, SW_S2P_SLOW} + lockExt;
            nxt_s.newN = SW_S2P_NEW;
          end else if (tgtSel[1] && s_ff.cur == MCK_MAIN) begin
            nxt_s.slowN = {5'h00, SW_X2P_SLOW} + lockExt;
            nxt_s.newN = SW_X2P_NEW;
          end else if (tgtSel[1]) begin
            // the other PLL is assumed running: no relock
            nxt_s.slowN = {5'h00, SW_X2P_SLOW};
            nxt_s.newN = SW_P2P_NEW;
          end else if (tgtSel == MCK_SLOW && s_ff.cur[1]) begin
            nxt_s.oldN = SW_P2S_OLD;
            nxt_s.slowN = {5'h00, SW_P2S_SLOW};
          end else if (tgtSel == MCK_MAIN) begin
            nxt_s.oldN = SW_P2M_OLD;
            nxt_s.slowN = {5'h00, SW_X2P_SLOW};
            nxt_s.newN = SW_P2M_NEW;
          end
        end
      end
      PCLK_SW_OLD: begin
        if (s_ff.cnt == {5'h00, s_ff.oldN}) begin
          nxt_s.cnt = 9'h000;
          nxt_s.st = PCLK_SW_SLOW;
        end else if (selTick(s_ff.cur, mainTick, slowTick, pllaTick,
                             upllTick)) begin
          nxt_s.cnt = s_ff.cnt + 9'h001;
        end
      end
      PCLK_SW_SLOW: begin
        if (s_ff.cnt == s_ff.slowN) begin
          nxt_s.cnt = 9'h000;
          nxt_s.cur = s_ff.tgt;
          nxt_s.st = PCLK_SW_NEW;
        end else if (slowTick) begin
          nxt_s.cnt = s_ff.cnt + 9'h001;
        end
      end
      PCLK_SW_NEW: begin
        if (s_ff.cnt == {5'h00, s_ff.newN}) begin
          nxt_s.cnt = 9'h000;
          nxt_s.st = presOn ? PCLK_SW_PROGCLK_PRESCALER : PCLK_SW_IDLE;
          nxt_s.busy = presOn;
          nxt_s.done = !presOn;
        end else if (selTick(s_ff.cur, mainTick, slowTick, pllaTick,
                             upllTick)) begin
          nxt_s.cnt = s_ff.cnt + 9'h001;
        end
      end
      PCLK_SW_PROGCLK_PRESCALER: begin
        if (s_ff.cnt == MCK_PROGCLK_PRESCALER_EXTRA) begin
          nxt_s.st = PCLK_SW_IDLE;
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
        end else if (selTick(s_ff.cur, mainTick, slowTick, pllaTick,
                             upllTick)) begin
          nxt_s.cnt = s_ff.cnt + 9'h001;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign curSel = s_ff.cur;
  assign busy = s_ff.busy;
  assign donePulse = s_ff.done;

  property p_stableIdle;
    @(posedge clk) disable iff (rst) !busy && !$past(busy) |-> $stable(curSel);
  endproperty
  a_stableIdle: assert property (p_stableIdle) else $error("source moved");
  property p_doneEnd;
    @(posedge clk) disable iff (rst) donePulse |-> !busy && curSel == s_ff.tgt;
  endproperty
  a_doneEnd: assert property (p_doneEnd) else $error("bad switch end");
endmodule

// [pclk_top.sv]
// register file, AXI4-Lite slave and clock outputs of the clock block
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
module pclk_top import pclk_pkg::*; #(
  parameter int NPCK = NUM_PCK
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mainTick,
  input wire logic slowClockTick,
  input wire logic pllAOutputTick,
  input wire logic usbPllOutputTick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NPCK-1:0] progclkOutput,
  output logic [31:0] periphClkEn,
  output logic [1:0] masterClkSel,
  output logic irq
);
  typedef struct packed {
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic awFull;
    logic [7:0] awAddr;
    logic wFull;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [31:0] periphEn;
    logic [NPCK-1:0] pckEn;
    logic [NPCK-1:0][2:0] progclk_source_select;
    logic [NPCK-1:0][7:0] progclk_prescaler;
    logic [1:0] mckCss;
    logic mckPresOn;
    logic [7:0] lockCnt;
    logic [STAT_W-1:0] isr;
    logic [STAT_W-1:0] imr;
    logic [NPCK-1:0] rdyPrev;
    logic irq;
  } pclk_regs_t;
  pclk_regs_t s_ff, nxt_s;

  logic [NPCK-1:0] pckReady;
  logic mckBusy;
  logic mckDone;
  logic [1:0] mckCur;
  logic [31:0] wMask;
  logic [31:0] wd;
  logic [31:0] oldCfg;
  logic [31:0] newCfg;
  logic [STAT_W-1:0] setEv;
  logic [STAT_W-1:0] clrEv;
  logic [STAT_W-1:0] status;
  logic hit;

  //------------------------------------------------------------------
  // clock outputs and master switch
  //------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPCK; g++) begin : gPck
      pclk_divider uDiv (
        .clk(clk),
        .rst(rst),
        .enable(s_ff.pckEn[g]),
        .srcSel(s_ff.progclk_source_select[g]),
        .progclk_prescaler(s_ff.progclk_prescaler[g]),
        .mainTick(mainTick),
        .slowTick(slowClockTick),
        .pllaTick(pllAOutputTick),
        .upllTick(usbPllOutputTick),
        .pckOut(progclkOutput[g]),
        .ready(pckReady[g])
      );
    end
  endgenerate

  pclk_mck_switch uSw (
    .clk(clk),
    .rst(rst),
    .tgtSel(s_ff.mckCss),
    .presOn(s_ff.mckPresOn),
    .lockCnt(s_ff.lockCnt),
    .mainTick(mainTick),
    .slowTick(slowClockTick),
    .pllaTick(pllAOutputTick),
    .upllTick(usbPllOutputTick),
    .curSel(mckCur),
    .busy(mckBusy),
    .donePulse(mckDone)
  );

  //------------------------------------------------------------------
  // register file and bus slave
  //------------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    wMask = {{8{s_ff.wStrb[3]}}, {8{s_ff.wStrb[2]}},
             {8{s_ff.wStrb[1]}}, {8{s_ff.wStrb[0]}}};
    wd = s_ff.wData & wMask;
    oldCfg = 32'h0000_0000;
    newCfg = 32'h0000_0000;
    hit = 1'b0;
    clrEv = '0;
    status = '0;
    status[MCKRDY_BIT] = !mckBusy;
    status[NPCK-1:0] = pckReady;
    setEv = '0;
    setEv[MCKRDY_BIT] = mckDone;
    setEv[NPCK-1:0] = pckReady & ~s_ff.rdyPrev;
    nxt_s.rdyPrev = pckReady;
    if (s_axi_awvalid && s_ff.awRdy) begin
      nxt_s.awFull = 1'b1;
      nxt_s.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wRdy) begin
      nxt_s.wFull = 1'b1;
      nxt_s.wData = s_axi_wdata;
      nxt_s.wStrb = s_axi_wstrb;
    end
    if (s_ff.bValid && s_axi_bready) begin
      nxt_s.bValid = 1'b0;
    end
    if (s_ff.awFull && s_ff.wFull && !s_ff.bValid) begin
      nxt_s.awFull = 1'b0;
      nxt_s.wFull = 1'b0;
      nxt_s.bValid = 1'b1;
      nxt_s.bResp = RESP_OKAY;
      case (s_ff.awAddr)
        ADR_PCER: nxt_s.periphEn = s_ff.periphEn | wd;
        ADR_PCDR: nxt_s.periphEn = s_ff.periphEn & ~wd;
        ADR_SCER: nxt_s.pckEn = s_ff.pckEn | wd[NPCK-1:0];
        ADR_SCDR: nxt_s.pckEn = s_ff.pckEn & ~wd[NPCK-1:0];
        ADR_MCKR: begin
          if (s_ff.wStrb[0]) begin
            nxt_s.mckCss = s_ff.wData[MCK_CSS_LSB +: 2];
            nxt_s.mckPresOn = s_ff.wData[MCK_PROGCLK_PRESCALER_BIT];
          end
        end
        ADR_LOCK: begin
          if (s_ff.wStrb[0]) begin
            nxt_s.lockCnt = s_ff.wData[7:0];
          end
        end
        ADR_ISR: clrEv = wd[STAT_W-1:0];
        ADR_IMR: begin
          nxt_s.imr = (s_ff.imr & ~wMask[STAT_W-1:0]) | wd[STAT_W-1:0];
        end
        ADR_PCSR, ADR_SCSR, ADR_SR: hit = 1'b1;
        default: begin
          for (int i = 0; i < NPCK; i++) begin
            if (s_ff.awAddr == ADR_PCK0 + 8'(i * 4)) begin
              hit = 1'b1;
              oldCfg[CSS_LSB +: 3] = s_ff.progclk_source_select[i];
              oldCfg[PROGCLK_PRESCALER_LSB +: 8] = s_ff.progclk_prescaler[i];
              newCfg = (oldCfg & ~wMask) | wd;
              // source and prescaler land together; a live clock takes
              // them at once, hence the disable-first sequence
              nxt_s.progclk_source_select[i] = newCfg[CSS_LSB +: 3];
              nxt_s.progclk_prescaler[i] = newCfg[PROGCLK_PRESCALER_LSB +: 8];
            end
          end
          if (!hit) begin
            nxt_s.bResp = RESP_SLVERR;
          end
        end
      endcase
    end
    // a new event beats a simultaneous clear
    nxt_s.isr = (s_ff.isr & ~clrEv) | setEv;
    nxt_s.irq = |(nxt_s.isr & nxt_s.imr);
    nxt_s.awRdy = !nxt_s.awFull;
    nxt_s.wRdy = !nxt_s.wFull;
    if (s_ff.rValid && s_axi_rready) begin
      nxt_s.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arRdy) begin
      nxt_s.rValid = 1'b1;
      nxt_s.rResp = RESP_OKAY;
      nxt_s.rData = 32'h0000_0000;
      case (s_axi_araddr)
        ADR_PCER, ADR_PCDR, ADR_SCER, ADR_SCDR: nxt_s.rData = 32'h0000_0000;
        ADR_PCSR: nxt_s.rData = s_ff.periphEn;
        ADR_SCSR: nxt_s.rData[NPCK-1:0] = s_ff.pckEn;
        ADR_MCKR: begin
          nxt_s.rData[MCK_CSS_LSB +: 2] = s_ff.mckCss;
          nxt_s.rData[MCK_PROGCLK_PRESCALER_BIT] = s_ff.mckPresOn;
        end
        ADR_LOCK: nxt_s.rData[7:0] = s_ff.lockCnt;
        ADR_SR: nxt_s.rData[STAT_W-1:0] = status;
        ADR_ISR: nxt_s.rData[STAT_W-1:0] = s_ff.isr;
        ADR_IMR: nxt_s.rData[STAT_W-1:0] = s_ff.imr;
        default: begin
          nxt_s.rResp = RESP_SLVERR;
          for (int i = 0; i < NPCK; i++) begin
            if (s_axi_araddr == ADR_PCK0 + 8'(i * 4)) begin
              nxt_s.rResp = RESP_OKAY;
              nxt_s.rData[CSS_LSB +: 3] = s_ff.progclk_source_select[i];
              nxt_s.rData[PROGCLK_PRESCALER_LSB +: 8] = s_ff.progclk_prescaler[i];
            end
          end
        end
      endcase
    end
    nxt_s.arRdy = !nxt_s.rValid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
      for (int i = 0; i < NPCK; i++) begin
        s_ff.progclk_source_select[i] <= CSS_RST;
        s_ff.progclk_prescaler[i] <= PROGCLK_PRESCALER_RST;
      end
      s_ff.lockCnt <= LOCK_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready = s_ff.awRdy;
  assign s_axi_wready = s_ff.wRdy;
  assign s_axi_arready = s_ff.arRdy;
  assign s_axi_bvalid = s_ff.bValid;
  assign s_axi_bresp = s_ff.bResp;
  assign s_axi_rvalid = s_ff.rValid;
  assign s_axi_rdata = s_ff.rData;
  assign s_axi_rresp = s_ff.rResp;
  assign periphClkEn = s_ff.periphEn;
  assign masterClkSel = mckCur;
  assign irq = s_ff.irq;

  //------------------------------------------------------------------
  // checks
  //------------------------------------------------------------------
  sequence s_wrDo(logic [7:0] a);
    s_ff.awFull && s_ff.wFull && !s_ff.bValid && s_ff.awAddr == a;
  endsequence
  property p_resetCfg;
    @(posedge clk) $past(rst) && !rst |->
      s_ff.progclk_source_select[0] == SRC_SLOW && s_ff.progclk_prescaler[0] == 8'h00;
  endproperty
  a_resetCfg: assert property (p_resetCfg) else $error("bad reset cfg");
  property p_pcer;
    @(posedge clk) disable iff (rst) s_wrDo(ADR_PCER) ##0 wd[0] |=>
      periphClkEn[0];
  endproperty
  a_pcer: assert property (p_pcer) else $error("enable not applied");
  property p_pcdr;
    @(posedge clk) disable iff (rst) s_wrDo(ADR_PCDR) ##0 wd[0] |=>
      !periphClkEn[0];
  endproperty
  a_pcdr: assert property (p_pcdr) else $error("disable not applied");
  property p_setWins;
    @(posedge clk) disable iff (rst) pckReady[0] && !s_ff.rdyPrev[0] |=>
      s_ff.isr[0];
  endproperty
  a_setWins: assert property (p_setWins) else $error("ready event lost");
  property p_irqGate;
    @(posedge clk) disable iff (rst) s_ff.isr[0] && !s_ff.imr[0] &&
      (s_ff.isr[STAT_W-1:1] & s_ff.imr[STAT_W-1:1]) == '0 |-> !irq;
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("masked irq");
  property p_bResp;
    @(posedge clk) disable iff (rst)
      s_ff.awFull && s_ff.wFull && !s_ff.bValid |=> s_axi_bvalid;
  endproperty
  a_bResp: assert property (p_bResp) else $error("no write response");
endmodule

// [test_pclk_top.sv]
// self-checking testbench of the programmable clock and switch block
`timescale 1ns/10ps
module test_pclk_top import pclk_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mainTick = 1'b0;
  logic slowClockTick = 1'b0;
  logic pllAOutputTick = 1'b0;
  logic usbPllOutputTick = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, masterClkSel;
  logic [31:0] s_axi_rdata, periphClkEn;
  logic [NUM_PCK-1:0] progclkOutput;
  int numErrors = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h9662724A;

  pclk_top #(.NPCK(NUM_PCK)) i_pclk_top (.clk(clk), .rst(rst),
    .mainTick(mainTick), .slowClockTick(slowClockTick),
    .pllAOutputTick(pllAOutputTick), .usbPllOutputTick(usbPllOutputTick),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .progclkOutput(progclkOutput),
    .periphClkEn(periphClkEn), .masterClkSel(masterClkSel), .irq(irq));

  always #20 clk = ~clk;

  //------------------------------------------------------------------
  // source ticks: distinct rates so a wrong source shows as wrong period
  //------------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mainTick <= (cyc % 2 == 0);
    slowClockTick <= (cyc % 3 == 0);
    pllAOutputTick <= (cyc % 4 == 0);
    usbPllOutputTick <= (cyc % 5 == 0);
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // source code to tick period in clk cycles
  function automatic int srcPer(input int s);
    int t[5] = '{3, 2, 1, 4, 5};
    return t[s];
  endfunction

  //------------------------------------------------------------------
  // checking and bus tasks
  //------------------------------------------------------------------
  task automatic conclude();
    if (numErrors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    chk(32'h0, 32'h1);
    conclude();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1 && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1 && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (n > 50) hang();
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1 && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (n > 50) hang();
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, RESP_OKAY);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask

  // poll until a status bit shows the wanted value
  task automatic waitBit(input logic [7:0] a, input int b, input logic v);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(a, d, r);
      n++;
      if (n > 100) hang();
    end while (d[b] !== v);
  endtask

  // gap between two later output pulses, first pulses may be partial
  task automatic per(input int i, input int e);
    int n, t;
    n = 0;
    t = 0;
    repeat (3) begin
      t = 0;
      do begin
        @(posedge clk);
        t++;
        n++;
        if (n > 400) hang();
      end while (progclkOutput[i] !== 1'b1);
    end
    chk(t, e);
  endtask

  // limit counts from after the write and includes slack for the polling reads
  task automatic ms(input logic [1:0] tgt, input logic pr, input int lim);
    int t0;
    wrOk(ADR_MCKR, {27'h0, pr, 2'h0, tgt});
    t0 = cyc;
    waitBit(ADR_SR, MCKRDY_BIT, 1'b1);
    chk(masterClkSel, tgt);
    chk(32'(cyc - t0 <= lim), 32'h1);
  endtask

  //------------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------------
  initial begin
    logic [31:0] d, m, c;
    logic [1:0] r;
    int i, p;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdChk(ADR_PCK0, 32'h0);
    rdChk(ADR_LOCK, {24'h0, LOCK_RST});
    rdChk(ADR_IMR, 32'h0);
    rd(8'h3C, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h3C, rnd(), r);
    chk(r, RESP_SLVERR);
    wrOk(ADR_SCER, 32'h1);
    waitBit(ADR_SR, 0, 1'b1);
    per(0, 3);
    wrOk(ADR_SCDR, 32'h1);
    // every source, random output and prescaler, each one reconfigured
    for (int s = 0; s < 5; s++) begin
      i = int'(rnd() % NUM_PCK);
      p = int'(rnd() % 4);
      wrOk(ADR_PCK0 + 8'(4 * i), {20'h0, p[7:0], 1'b0, s[2:0]});
      rdChk(ADR_PCK0 + 8'(4 * i), {20'h0, p[7:0], 1'b0, s[2:0]});
      wrOk(ADR_SCER, 32'h1 << i);
      waitBit(ADR_SR, i, 1'b1);
      per(i, srcPer(s) * (p + 1));
      chk(irq, 1'b0);
      wrOk(ADR_IMR, 32'h1 << i);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      wrOk(ADR_SCDR, 32'h1 << i);
      rd(ADR_SR, d, r);
      chk(d[i], 1'b0);
      wrOk(ADR_ISR, 32'h1FF);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      wrOk(ADR_IMR, 32'h0);
    end
    // low bit forced so the enable and disable checks both fire
    m = rnd() | 32'h1;
    wrOk(ADR_PCER, m);
    repeat (2) @(posedge clk);
    chk(periphClkEn, m);
    c = rnd() | 32'h1;
    wrOk(ADR_PCDR, c);
    repeat (2) @(posedge clk);
    chk(periphClkEn, m & ~c);
    rdChk(ADR_PCSR, m & ~c);
    // short lock count keeps the PLL switches brief
    wrOk(ADR_LOCK, 32'h2);
    ms(MCK_MAIN, 1'b0, 25);
    ms(MCK_SLOW, 1'b0, 23);
    ms(MCK_PLLA, 1'b0, 39);
    ms(MCK_SLOW, 1'b0, 35);
    ms(MCK_MAIN, 1'b1, 153);
    rdChk(ADR_MCKR, 32'h11);
    ms(MCK_UPLL, 1'b0, 39);
    ms(MCK_PLLA, 1'b0, 38);
    ms(MCK_MAIN, 1'b0, 34);
    wrOk(ADR_IMR, 32'h100);
    chk(irq, 1'b1);
    conclude();
  end
endmodule
